// ==== hw/vtx_cmd_decoder.sv ====
// Decoder end: assembles vectors and routes them by command type.
// Assumes the source keeps address bits 1:0 zero and issues tokens.
`timescale 1ns/1ps
module vtx_cmd_decoder #(
  parameter int VEC_TOP = 13,
  parameter int PROG_DEPTH = 64,
  parameter int CTX_DEPTH = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link
  vtx_cmd_if.decoder lnk,
  // Side outputs
  output logic [127:0] mode_o,
  output logic [8:0] run_pc_o,
  output logic run_start_o,
  output logic busy_o
);
  // Refuse vector fields the address cannot hold
  if (VEC_TOP < vtx_cmd_pkg::VEC_TOP_MIN || VEC_TOP > 13)
  begin : g_bad_top
    $error("VEC_TOP out of range");
  end
  localparam int AW = $clog2(PROG_DEPTH);
  localparam int CW = $clog2(CTX_DEPTH);
  localparam int NV = 17;

  logic [127:0] vab_reg [NV];
  logic [127:0] input_vertex_buffer_reg;
  logic [127:0] mode_reg;
  logic [2:0] pend_reg;
  logic [2:0] proc_reg;
  logic sync_reg;
  logic out_valid_reg;
  logic [31:0] out_data_reg;
  logic out_vert_reg;
  logic rd_pend_reg;
  logic [3:0] rd_type_reg;
  logic [1:0] rd_word_reg;
  logic [31:0] rd_vab_reg;
  logic [8:0] pc_reg;
  logic run_reg;
  logic [21:0] lt_ram [5][CTX_DEPTH];
  logic [21:0] lt_rd_reg;

  wire busy = proc_reg != 3'h0;
  wire ready = !sync_reg && !busy;
  wire take = lnk.cmd_valid && ready;
  wire [3:0] typ = lnk.cmd_type;
  wire [1:0] word = lnk.cmd_addr[3:2];
  wire [9:0] vsel = 10'(lnk.cmd_addr[VEC_TOP:vtx_cmd_pkg::VEC_LSB]);
  wire is_wr = take && lnk.cmd_op == vtx_cmd_pkg::OP_WRITE;
  wire is_rd = take && lnk.cmd_op == vtx_cmd_pkg::OP_READ;
  wire is_trig = take && lnk.cmd_op == vtx_cmd_pkg::OP_TRIGGER;
  wire [4:0] slot = (typ == vtx_cmd_pkg::T_ATTR && vsel < 10'd16) ?
    vsel[4:0] : 5'd16;
  wire [31:0] w0 = vtx_cmd_pkg::fp_canon(lnk.cmd_data[63:32]);
  wire [31:0] w1 = vtx_cmd_pkg::fp_canon(lnk.cmd_data[31:0]);
  wire pair = lnk.cmd_pair && !word[0];
  wire last = pair ? word == 2'h2 : word == vtx_cmd_pkg::W_COMP;
  wire attr_x = typ == vtx_cmd_pkg::T_ATTR && slot != 5'd16 && word == 2'h0;

  function automatic logic [127:0] merge(input logic [127:0] v,
    input logic [1:0] w, input logic p, input logic [31:0] a,
    input logic [31:0] b);
    logic [127:0] r;
    r = v;
    r[(3 - w) * 32 +: 32] = a;
    if (p)
      r[(2 - w) * 32 +: 32] = b;
    merge = r;
  endfunction : merge

  wire [127:0] base = attr_x ?
    {vab_reg[slot][127:96], 64'h0, vtx_cmd_pkg::ONE_F} : vab_reg[slot];
  wire [127:0] vec_new = merge(base, word, pair, w0, w1);
  wire stores = is_wr && typ != vtx_cmd_pkg::T_UNDEF &&
    typ != vtx_cmd_pkg::T_RUN;
  wire fwd = is_wr && last;
  wire prog_we = fwd && (typ == vtx_cmd_pkg::T_PROG ||
    typ == vtx_cmd_pkg::T_EXTRA_PROGRAM_SLOT_COMMAND);
  wire ctx_we = fwd && typ == vtx_cmd_pkg::T_CTX;
  wire lt_we = fwd && typ >= vtx_cmd_pkg::T_LIGHTING_PARAMETER_RAM &&
    typ <= vtx_cmd_pkg::T_LIGHTING_FACTOR_RAM_3;
  wire [2:0] lt_idx = 3'(typ - vtx_cmd_pkg::T_LIGHTING_PARAMETER_RAM);
  wire [AW-1:0] prog_a = {typ == vtx_cmd_pkg::T_EXTRA_PROGRAM_SLOT_COMMAND, vsel[AW-2:0]};
  wire [AW-1:0] prog_ra = {lnk.cmd_type == vtx_cmd_pkg::T_EXTRA_PROGRAM_SLOT_COMMAND,
    vsel[AW-2:0]};
  wire rd_ok = is_rd && vtx_cmd_pkg::type_readable(typ);
  wire [31:0] prog_rd;
  wire [31:0] ctx_rd;

  vtx_word_ram #(.DEPTH(PROG_DEPTH)) u_prog (
    .clk_i(clk_i), .we_i(prog_we), .waddr_i(prog_a), .wdata_i(vec_new),
    .raddr_i(prog_ra), .rword_i(word), .rdata_o(prog_rd)
  );
  vtx_word_ram #(.DEPTH(CTX_DEPTH)) u_ctx (
    .clk_i(clk_i), .we_i(ctx_we), .waddr_i(vsel[CW-1:0]),
    .wdata_i(vec_new), .raddr_i(vsel[CW-1:0]), .rword_i(word),
    .rdata_o(ctx_rd)
  );

  always_ff @(posedge clk_i)
  begin
    if (lt_we)
      lt_ram[lt_idx][vsel[CW-1:0]] <=
        vtx_cmd_pkg::lt_float(vec_new[127:96]);
    lt_rd_reg <= lt_ram[lt_idx][vsel[CW-1:0]];
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < NV; i++)
        vab_reg[i] <= 128'h0;
    end
    else if (stores)
      vab_reg[slot] <= vec_new;
  end

  wire [31:0] rd_data = (rd_type_reg == vtx_cmd_pkg::T_ATTR) ? rd_vab_reg :
    (rd_type_reg == vtx_cmd_pkg::T_CTX) ? ctx_rd :
    (rd_type_reg >= vtx_cmd_pkg::T_LIGHTING_PARAMETER_RAM) ? {lt_rd_reg, 10'h0} : prog_rd;
  wire run_go = is_wr && typ == vtx_cmd_pkg::T_RUN;
  wire pass_go = fwd && typ == vtx_cmd_pkg::T_PASS;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      input_vertex_buffer_reg <= 128'h0;
      mode_reg <= 128'h0;
      pend_reg <= 3'h0;
      proc_reg <= 3'h0;
      sync_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_data_reg <= 32'h0;
      out_vert_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_type_reg <= 4'h0;
      rd_word_reg <= 2'h0;
      rd_vab_reg <= 32'h0;
      pc_reg <= 9'h0;
      run_reg <= 1'b0;
    end
    else
    begin
      out_valid_reg <= 1'b0;
      out_vert_reg <= 1'b0;
      run_reg <= run_go;
      rd_pend_reg <= rd_ok;
      if (rd_ok)
      begin
        rd_type_reg <= typ;
        rd_word_reg <= word;
        rd_vab_reg <= vab_reg[slot][(3 - word) * 32 +: 32];
      end
      if (fwd && typ == vtx_cmd_pkg::T_MODE)
        mode_reg <= vec_new;
      if (ctx_we || lt_we || pass_go)
        input_vertex_buffer_reg <= vec_new;
      if (run_go)
      begin
        input_vertex_buffer_reg <= vab_reg[16];
        pc_reg <= lnk.cmd_data[40:32];
      end
      if (is_trig)
      begin
        input_vertex_buffer_reg <= vab_reg[0];
        proc_reg <= vtx_cmd_pkg::VTX_PROC_CYCLES;
      end
      else if (busy)
        proc_reg <= proc_reg - 3'h1;
      if (is_wr && typ == vtx_cmd_pkg::T_SYNC)
        sync_reg <= 1'b1;
      else if (!busy)
        sync_reg <= 1'b0;
      if (pass_go)
      begin
        out_valid_reg <= 1'b1;
        out_data_reg <= vec_new[127:96];
      end
      else if (proc_reg == 3'h1)
      begin
        out_valid_reg <= 1'b1;
        out_vert_reg <= 1'b1;
        out_data_reg <= input_vertex_buffer_reg[127:96];
      end
      else if (rd_pend_reg)
      begin
        out_valid_reg <= 1'b1;
        out_data_reg <= rd_data;
      end
    end
  end

  assign lnk.cmd_ready = ready;
  assign lnk.out_valid = out_valid_reg;
  assign lnk.out_data = out_data_reg;
  assign lnk.out_is_vertex = out_vert_reg;
  assign mode_o = mode_reg;
  assign run_pc_o = pc_reg;
  assign run_start_o = run_reg;
  assign busy_o = busy;
endmodule : vtx_cmd_decoder

// ==== hw/vtx_cmd_if.sv ====
// Interface joining the upstream command source and the decoder.
// Assumes both ends share clk_i and rst_b_i.
`timescale 1ns/1ps
interface vtx_cmd_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [1:0] cmd_op;
  logic [3:0] cmd_type;
  logic [13:0] cmd_addr;
  logic cmd_pair;
  logic [63:0] cmd_data;
  logic out_valid;
  logic [31:0] out_data;
  logic out_is_vertex;
  logic token_valid;
  logic token_is_vertex;
  modport decoder (
    input cmd_valid, cmd_op, cmd_type, cmd_addr, cmd_pair, cmd_data,
    output cmd_ready, out_valid, out_data, out_is_vertex
  );
  modport source (
    output cmd_valid, cmd_op, cmd_type, cmd_addr, cmd_pair, cmd_data,
    output token_valid, token_is_vertex,
    input cmd_ready, out_valid, out_data, out_is_vertex
  );
endinterface : vtx_cmd_if

// ==== hw/vtx_cmd_pkg.sv ====
// Package with shared constants and types for the command decoder ends.
// Assumes a single core clock and active-low asynchronous reset.
// Contract
// - Write carries type, address, one or two words
// - Upstream drives address bits 1:0 as zero
// - Address bits 3:2 pick word, 0 is X
// - Address bits 4 upward pick the vector
// - Read returns one word, invalid read dropped
// - Write updates one word or aligned pair
// - Words 0-2 stored, word 3 forwards vector
// - Type 0 stores slot only, not readable
// - Type 1 writes or reads attribute buffer
// - Type 2 assembles and writes program RAM
// - Type 4 stages parameter in slot only
// - Type 6 copies parameter, starts state program
// - Type 5 passes payload out, token required
// - Type 7 loads mode-control storage, not readable
// - Type 8 writes extra program slots
// - Type 9 routes to parameter RAM, readable
// - Types a-e route to lighting RAMs, readable
// - Type f blocks until vertices finish
// - Trigger processes vertex, emitted when done
// - Cache consumes output only after token
// - Flush denormals, canonical NaN pattern
// - Lighting float drops low ten bits
package vtx_cmd_pkg;
  localparam int ADDR_W = 14;
  localparam int WORD_LSB = 2;
  localparam int VEC_LSB = 4;
  localparam int VEC_TOP_MIN = 9;
  localparam int WORD_W = 32;
  localparam int VEC_W = 128;
  localparam int LT_DROP = 10;
  localparam int PC_W = 9;
  localparam logic [31:0] CANON_NAN = 32'h7FFFFFFF;
  localparam logic [31:0] ONE_F = 32'h3F800000;
  localparam logic [2:0] VTX_PROC_CYCLES = 3'h4;
  localparam logic [1:0] W_COMP = 2'h3;

  typedef enum logic [3:0] {
    T_NOP = 4'h0, T_ATTR = 4'h1, T_PROG = 4'h2, T_UNDEF = 4'h3,
    T_STAGE_PARAMETER_COMMAND = 4'h4, T_PASS = 4'h5, T_RUN = 4'h6, T_MODE = 4'h7,
    T_EXTRA_PROGRAM_SLOT_COMMAND = 4'h8, T_CTX = 4'h9, T_LIGHTING_PARAMETER_RAM = 4'hA, T_LIGHTING_FACTOR_RAM_0 = 4'hB,
    T_LIGHTING_FACTOR_RAM_1 = 4'hC, T_LIGHTING_FACTOR_RAM_2 = 4'hD, T_LIGHTING_FACTOR_RAM_3 = 4'hE, T_SYNC = 4'hF
  } cmd_type_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0, OP_READ = 2'h1, OP_TRIGGER = 2'h2
  } cmd_op_t;

  function automatic logic type_readable(input logic [3:0] t);
    type_readable = (t == 4'h1) || (t == 4'h2) ||
      (t >= 4'h8 && t <= 4'hE);
  endfunction : type_readable

  function automatic logic [31:0] fp_canon(input logic [31:0] v);
    if (v[30:23] == 8'h00)
      fp_canon = {v[31], 31'h0};
    else if (v[30:23] == 8'hFF && v[22:0] != 23'h0)
      fp_canon = CANON_NAN;
    else
      fp_canon = v;
  endfunction : fp_canon

  function automatic logic [21:0] lt_float(input logic [31:0] v);
    lt_float = v[31:LT_DROP];
  endfunction : lt_float
endpackage : vtx_cmd_pkg

// ==== hw/vtx_cmd_source.sv ====
// Upstream end: issues commands and the matching side tokens.
// Assumes the user holds a request until req_ready_o.
`timescale 1ns/1ps
module vtx_cmd_source (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // User request
  input wire logic req_valid_i,
  input wire logic [1:0] req_op_i,
  input wire logic [3:0] req_type_i,
  input wire logic [11:0] req_word_addr_i,
  input wire logic req_pair_i,
  input wire logic [63:0] req_data_i,
  output logic req_ready_o,
  // Results
  output logic res_valid_o,
  output logic [31:0] res_data_o,
  // Link
  vtx_cmd_if.source lnk
);
  logic busy_reg;
  logic res_valid_reg;
  logic [31:0] res_data_reg;
  wire send = req_valid_i && !busy_reg && lnk.cmd_ready;
  wire tok = send && ((req_op_i == vtx_cmd_pkg::OP_WRITE &&
    req_type_i == vtx_cmd_pkg::T_PASS) ||
    req_op_i == vtx_cmd_pkg::OP_TRIGGER);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy_reg <= 1'b0;
      res_valid_reg <= 1'b0;
      res_data_reg <= 32'h0;
    end
    else
    begin
      busy_reg <= send;
      res_valid_reg <= lnk.out_valid;
      if (lnk.out_valid)
        res_data_reg <= lnk.out_data;
    end
  end

  assign lnk.cmd_valid = busy_reg ? 1'b0 : req_valid_i;
  assign lnk.cmd_op = req_op_i;
  assign lnk.cmd_type = req_type_i;
  assign lnk.cmd_addr = {req_word_addr_i, 2'b00};
  assign lnk.cmd_pair = req_pair_i;
  assign lnk.cmd_data = req_data_i;
  assign lnk.token_valid = tok;
  assign lnk.token_is_vertex = req_op_i == vtx_cmd_pkg::OP_TRIGGER;
  assign req_ready_o = send;
  assign res_valid_o = res_valid_reg;
  assign res_data_o = res_data_reg;
endmodule : vtx_cmd_source

// ==== hw/vtx_word_ram.sv ====
// Vector RAM with whole-vector write and single-word read.
// Assumes synchronous one-cycle read latency.
`timescale 1ns/1ps
module vtx_word_ram #(
  parameter int DEPTH = 64
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [127:0] wdata_i,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  input wire logic [1:0] rword_i,
  output logic [31:0] rdata_o
);
  logic [127:0] mem [DEPTH];
  wire [127:0] rvec = mem[raddr_i];
  always_ff @(posedge clk_i)
  begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
  end
  always_ff @(posedge clk_i)
  begin
    rdata_o <= rvec[(3 - rword_i) * 32 +: 32];
  end
endmodule : vtx_word_ram

// ==== sim/tb_vtx_cmd_decoder.sv ====
// Bench for source and decoder joined by the link interface.
// Assumes the source user port and decoder side outputs only.
`timescale 1ns/1ps
module tb_vtx_cmd_decoder;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic [1:0] req_op_i = 2'h0;
  logic [3:0] req_type_i = 4'h0;
  logic [11:0] req_word_addr_i = 12'h000;
  logic req_pair_i = 1'b0;
  logic [63:0] req_data_i = 64'h0;
  logic req_ready_o;
  logic res_valid_o;
  logic [31:0] res_data_o;
  logic [127:0] mode_o;
  logic [8:0] run_pc_o;
  logic run_start_o;
  logic busy_o;
  logic [31:0] resq[$];
  logic [3:0] bad[6] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h7, 4'hF};
  int miscompares = 0;
  int checks = 0;
  int starts = 0;
  int busy_seen = 0;
  vtx_cmd_if lnk ();
  vtx_cmd_source vtx_cmd_source_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .req_valid_i(req_valid_i), .req_op_i(req_op_i),
    .req_type_i(req_type_i), .req_word_addr_i(req_word_addr_i),
    .req_pair_i(req_pair_i), .req_data_i(req_data_i),
    .req_ready_o(req_ready_o), .res_valid_o(res_valid_o),
    .res_data_o(res_data_o), .lnk(lnk));
  vtx_cmd_decoder vtx_cmd_decoder_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .lnk(lnk), .mode_o(mode_o), .run_pc_o(run_pc_o),
    .run_start_o(run_start_o), .busy_o(busy_o));
  vtx_link_checker vtx_link_checker_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .cmd_valid(lnk.cmd_valid),
    .cmd_ready(lnk.cmd_ready), .cmd_op(lnk.cmd_op),
    .cmd_type(lnk.cmd_type), .cmd_addr(lnk.cmd_addr),
    .cmd_pair(lnk.cmd_pair), .out_valid(lnk.out_valid),
    .out_is_vertex(lnk.out_is_vertex));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (res_valid_o === 1'b1)
      resq.push_back(res_data_o);
    if (run_start_o === 1'b1)
      starts++;
    if (busy_o === 1'b1)
      busy_seen++;
  end
  function automatic logic [31:0] pat(input logic [3:0] t,
    input logic [1:0] w);
    pat = {20'h41230, t, 6'h0, w};
  endfunction : pat
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [1:0] op, input logic [3:0] ty,
    input logic [11:0] wa, input logic pr, input logic [63:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_op_i = op;
    req_type_i = ty;
    req_word_addr_i = wa;
    req_pair_i = pr;
    req_data_i = d;
    #5;
    while (req_ready_o !== 1'b1 && n < 50)
    begin
      @(negedge clk_i);
      #5;
      n++;
    end
    chk(128'(n < 50), 128'h1);
    @(negedge clk_i);
    req_valid_i = 1'b0;
  endtask : send
  task automatic expect_n(input int n, output logic [31:0] v);
    repeat (6) @(negedge clk_i);
    chk(128'(resq.size()), 128'(n));
    v = (resq.size() != 0) ? resq[0] : 32'h0;
    resq.delete();
  endtask : expect_n
  task automatic rd(input logic [3:0] ty, input logic [11:0] wa,
    input logic [31:0] exp);
    logic [31:0] v;
    send(2'h1, ty, wa, 1'b0, 64'h0);
    expect_n(1, v);
    chk(128'(v), 128'(exp));
  endtask : rd
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (2000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
  initial
  begin
    logic [31:0] v;
    logic [3:0] ty;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    // Program, extra slot and parameter spaces
    for (int t = 0; t < 3; t++)
    begin
      ty = (t == 0) ? 4'h2 : (t == 1) ? 4'h8 : 4'h9;
      send(2'h0, ty, 12'h054, 1'b1, {pat(ty, 0), pat(ty, 1)});
      send(2'h0, ty, 12'h056, 1'b0, {2{pat(ty, 2)}});
      send(2'h0, ty, 12'h057, 1'b0, {2{pat(ty, 3)}});
      for (int w = 0; w < 4; w++)
        rd(ty, {10'h015, 2'(w)}, pat(ty, 2'(w)));
    end
    $display("vector space test done");
    // Attribute X write resets the rest
    send(2'h0, 4'h1, 12'h00C, 1'b1, {pat(1, 0), pat(1, 1)});
    send(2'h0, 4'h1, 12'h00E, 1'b1, {pat(1, 2), pat(1, 3)});
    send(2'h0, 4'h1, 12'h00C, 1'b0, {2{pat(5, 0)}});
    rd(4'h1, 12'h00C, pat(5, 0));
    rd(4'h1, 12'h00D, 32'h0);
    rd(4'h1, 12'h00E, 32'h0);
    rd(4'h1, 12'h00F, 32'h3F800000);
    $display("attribute test done");
    // Lighting spaces keep the reduced float
    for (int t = 10; t < 15; t++)
    begin
      send(2'h0, 4'(t), 12'h010, 1'b1, {32'h412345FF, 32'h1});
      send(2'h0, 4'(t), 12'h012, 1'b1, 64'h2);
      rd(4'(t), 12'h010, 32'h41234400);
    end
    $display("lighting test done");
    // Mode storage loads on the last word
    send(2'h0, 4'h7, 12'h000, 1'b1, {pat(7, 0), pat(7, 1)});
    expect_n(0, v);
    chk(mode_o, 128'h0);
    send(2'h0, 4'h7, 12'h002, 1'b1, {pat(7, 2), pat(7, 3)});
    expect_n(0, v);
    chk(mode_o, {pat(7, 0), pat(7, 1), pat(7, 2), pat(7, 3)});
    foreach (bad[i])
    begin
      send(2'h1, bad[i], 12'h000, 1'b0, 64'h0);
      expect_n(0, v);
    end
    $display("mode and drop test done");
    // Staged parameter then state program start
    send(2'h0, 4'h4, 12'h000, 1'b1, {pat(4, 0), pat(4, 1)});
    send(2'h0, 4'h4, 12'h002, 1'b1, {pat(4, 2), pat(4, 3)});
    expect_n(0, v);
    send(2'h0, 4'h6, 12'h003, 1'b0, {2{23'h0, 9'h1A5}});
    repeat (8) @(negedge clk_i);
    resq.delete();
    chk(128'(run_pc_o), 128'h1A5);
    chk(128'(starts), 128'h1);
    // Passthrough only on completion
    send(2'h0, 4'h5, 12'h000, 1'b1, 64'h5);
    expect_n(0, v);
    send(2'h0, 4'h5, 12'h002, 1'b1, 64'h6);
    expect_n(1, v);
    chk(128'(v), 128'h0);
    // Vertex trigger then barrier
    send(2'h2, 4'h0, 12'h000, 1'b0, 64'h0);
    send(2'h0, 4'hF, 12'h003, 1'b0, 64'h0);
    expect_n(1, v);
    chk(128'(busy_seen != 0), 128'h1);
    $display("run, pass and vertex test done");
    summarize();
  end
endmodule : tb_vtx_cmd_decoder

// ==== sim/vtx_link_checker.sv ====
// Assertions on the command link between source and decoder ends.
// Assumes instantiation beside the link interface in the bench top.
`timescale 1ns/1ps
module vtx_link_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link signals
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [3:0] cmd_type,
  input wire logic [13:0] cmd_addr,
  input wire logic cmd_pair,
  input wire logic out_valid,
  input wire logic out_is_vertex
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Accepted command classes
  wire take = cmd_valid && cmd_ready;
  wire can_rd = cmd_type == 4'h1 || cmd_type == 4'h2 ||
    (cmd_type >= 4'h8 && cmd_type <= 4'hE);
  wire rd_ok = take && cmd_op == 2'h1 && can_rd;
  wire rd_bad = take && cmd_op == 2'h1 && !can_rd;
  wire trig = take && cmd_op == 2'h2;
  wire last = take && cmd_op == 2'h0 && cmd_type == 4'h5 &&
    (cmd_addr[3:2] == 2'h3 || (cmd_pair && cmd_addr[3:2] == 2'h2));
  sequence s_vertex;
    ##5 out_valid && out_is_vertex;
  endsequence
  align_addr_a: assert property (cmd_valid |-> cmd_addr[1:0] == 2'h0)
    else $error("unaligned command address");
  hold_req_a: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_addr) && $stable(cmd_op))
    else $error("request changed while refused");
  read_answer_a: assert property (rd_ok |-> ##2 out_valid)
    else $error("read not answered");
  read_drop_a: assert property (rd_bad |-> ##2 !out_valid)
    else $error("unreadable read answered");
  pass_out_a: assert property (last |=> out_valid && !out_is_vertex)
    else $error("passthrough not emitted");
  vertex_out_a: assert property (trig |-> s_vertex)
    else $error("vertex not emitted in time");
  trig_hold_a: assert property (trig |=> !cmd_ready [*3])
    else $error("command taken during processing");
  no_spur_a: assert property (out_valid |->
    $past(trig, 5) || $past(last) || $past(rd_ok, 2))
    else $error("output without cause");
endmodule : vtx_link_checker
